// ===== hw/ebts_core.sv
// Cycle termination and dynamic bus sizing for the external bus unit.
// Assumes strobe timing, arbitration and chip selects live elsewhere;
// pin inputs are asynchronous and pass a two-stage synchroniser here.
//
// How it works
// - Acks: 11 wait, 10 byte, 01 word
// - Ack ends cycle and latches data
// - Chip-select may supply ack and autovector
// - Fault when cycle not properly terminated
// - Bus monitor faults our own transfers
// - Halt: single cycle; with fault, retry
// - Halted: data floats, address held
// - No interrupt service while halted
// - Autovector ends interrupt acknowledge only
// - No autovector under external master
// - Long via 16-bit port: two words
// - Long via 8-bit port: four bytes
// - Start each cycle assuming 16-bit port
// - Operand byte 0 first, byte 3 last
// - Address word base, offset, remaining size
// - Byte lane by offset; writes duplicated
// - Misaligned word and long refused
`default_nettype none

module ebts_core #(
	parameter int MONITOR_CYCLES = ebts_pkg::BUS_MONITOR_CYCLES
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Transfer request from the core
	input  wire logic        reqValid,
	input  wire logic        reqWrite,
	input  wire logic [2:0]  reqBytes,
	input  wire logic [23:0] reqAddr,
	input  wire logic [2:0]  reqSpace,
	input  wire logic        reqIntAck,
	input  wire logic [31:0] reqWdata,
	// Response to the core
	output logic             respValid,
	output logic             respFault,
	output logic             respAutoVector,
	output logic [31:0]      respRdata,
	output logic             busIdle,
	output logic             irqServiceHold,
	// Chip-select termination
	input  wire logic        csAckValid,
	input  wire logic        csAckWide,
	input  wire logic        csAutoVector,
	// Arbitration status
	input  wire logic        extMasterOwns,
	// Address, space, size and direction pins
	output logic [23:0]      addrOut,
	output logic             addrOe,
	output logic [2:0]       space_code,
	output logic [1:0]       remaining_size,
	output logic             readNotWrite,
	output logic             cycleActive,
	// Data pins
	input  wire logic [15:0] dataIn,
	output logic [15:0]      dataOut,
	output logic             dataOe,
	// Termination pins, active low
	input  wire logic        port_size_ack_hi_n,
	input  wire logic        port_size_ack_lo_n,
	input  wire logic        auto_vector_request_n,
	input  wire logic        haltRequest_n,
	input  wire logic        busFaultIn_n,
	output logic             busFaultOut,
	output logic             busFaultOe
);

	initial begin
		if (MONITOR_CYCLES < 4 || MONITOR_CYCLES > 255)
			$error("MONITOR_CYCLES out of range");
	end

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	localparam int SYNC_W = 21;
	logic [SYNC_W-1:0] syncMeta;
	logic [SYNC_W-1:0] syncPins;
	wire  [SYNC_W-1:0] rawPins = {dataIn, port_size_ack_hi_n, port_size_ack_lo_n,
	                              auto_vector_request_n, haltRequest_n, busFaultIn_n};

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			syncMeta <= '1;
			syncPins <= '1;
		end else begin
			syncMeta <= rawPins;
			syncPins <= syncMeta;
		end
	end

	wire [15:0] dataSync = syncPins[20:5];
	wire        ackHiN   = syncPins[4];
	wire        ackLoN   = syncPins[3];
	wire        avecReq  = ~syncPins[2];
	wire        haltReq  = ~syncPins[1];
	wire        faultPin = ~syncPins[0];

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	ebts_pkg::ebts_state_t state;
	logic [2:0]  remain;
	logic [31:0] wbuf;
	logic [31:0] rbuf;
	logic        retryPending;
	logic        intAck;
	logic [7:0]  monitorCount;

	// ----------------------------------------------------------------
	// Termination decode
	// ----------------------------------------------------------------
	// Pins and data lag two edges: anything sooner is left from the last piece
	wire pinsFresh = (monitorCount >= 8'h02);
	wire extAck8  = ackHiN & ~ackLoN;
	wire extAck16 = ~ackHiN & ackLoN;
	wire ack8  = pinsFresh & (extAck8 | (csAckValid & ~csAckWide));
	wire ack16 = pinsFresh & (extAck16 | (csAckValid & csAckWide));
	wire avecHit = pinsFresh & intAck & (avecReq | csAutoVector) & ~extMasterOwns;
	wire monitorExpired = (monitorCount == 8'(MONITOR_CYCLES - 1));
	// Fault wins even with an ack
	wire faultSeen = (pinsFresh & faultPin) | monitorExpired;
	wire ackSeen   = ack8 | ack16;
	wire running   = (state == ebts_pkg::ST_RUN);

	// ----------------------------------------------------------------
	// Sizing
	// ----------------------------------------------------------------
	function automatic logic [1:0] sizeCode(input logic [2:0] bytesLeft);
		unique case (bytesLeft)
			ebts_pkg::BYTES_LONG:  sizeCode = ebts_pkg::SIZE_LONG;
			ebts_pkg::BYTES_THREE: sizeCode = ebts_pkg::SIZE_THREE;
			ebts_pkg::BYTES_WORD:  sizeCode = ebts_pkg::SIZE_WORD;
			default:               sizeCode = ebts_pkg::SIZE_BYTE;
		endcase
	endfunction : sizeCode

	wire oddAddr = addrOut[ebts_pkg::OFFSET_BIT];
	// Two bytes moved when 16-bit port allows it
	wire twoBytes = ack16 & ~oddAddr & (remain >= ebts_pkg::BYTES_WORD);
	wire [2:0] moved     = twoBytes ? ebts_pkg::BYTES_WORD : ebts_pkg::BYTES_BYTE;
	wire [2:0] remainNew = remain - moved;
	// Word base and offset advance together
	wire [23:0] addrNew  = addrOut + {21'h000000, moved};

	// Byte port on upper lane only
	// 16-bit port odd byte on lower lane
	wire lowLane = ack16 & oddAddr;
	wire [7:0] readByte = lowLane ? dataSync[7:0]
	                              : dataSync[ebts_pkg::LANE_HI_MSB:ebts_pkg::LANE_HI_LSB];
	// Most significant byte shifts in first
	wire [31:0] rbufNew = twoBytes ? {rbuf[15:0], dataSync} : {rbuf[23:0], readByte};
	wire [31:0] wbufNew = twoBytes ? {wbuf[15:0], 16'h0000} : {wbuf[23:0], 8'h00};

	// Write byte duplicated on both lanes
	function automatic logic [15:0] laneData(input logic [31:0] wb, input logic odd,
			input logic [2:0] left);
		laneData = (!odd && left >= ebts_pkg::BYTES_WORD) ? wb[31:16]
		                                                  : {wb[31:24], wb[31:24]};
	endfunction : laneData

	wire [31:0] wbufStart  = reqWdata << (6'(ebts_pkg::BYTES_LONG - reqBytes) * 6'h08);
	wire [15:0] writeLanes = laneData(wbuf, oddAddr, remain);
	wire [15:0] startLanes = laneData(wbufStart, reqAddr[ebts_pkg::OFFSET_BIT], reqBytes);
	wire [15:0] nextLanes  = laneData(wbufNew, addrNew[ebts_pkg::OFFSET_BIT], remainNew);

	// ----------------------------------------------------------------
	// Request acceptance
	// ----------------------------------------------------------------
	// Odd word or long refused
	wire misaligned = reqAddr[ebts_pkg::OFFSET_BIT] & (reqBytes != ebts_pkg::BYTES_BYTE);
	wire badSize    = (reqBytes == 3'h0) | (reqBytes > ebts_pkg::BYTES_LONG);
	wire reqTake    = (state == ebts_pkg::ST_IDLE) & reqValid & ~extMasterOwns;
	wire reqStart   = reqTake & ~misaligned & ~badSize;

	wire cycleEnd  = running & (faultSeen | ackSeen | avecHit);
	wire lastPiece = (remainNew == 3'h0) | avecHit;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	ebts_pkg::ebts_state_t next_state;
	always_comb begin
		next_state = state;
		unique case (state)
			ebts_pkg::ST_IDLE:
				if (reqStart)
					next_state = ebts_pkg::ST_RUN;
			ebts_pkg::ST_RUN:
				if (cycleEnd) begin
					if (haltReq)
						next_state = ebts_pkg::ST_HALT;
					else if (faultSeen || lastPiece)
						next_state = ebts_pkg::ST_IDLE;
					else
						next_state = ebts_pkg::ST_GAP;
				end
			ebts_pkg::ST_GAP:
				next_state = ebts_pkg::ST_RUN;
			ebts_pkg::ST_HALT:
				if (!haltReq && !extMasterOwns)
					next_state = (retryPending || remain != 3'h0) ? ebts_pkg::ST_RUN
					                                             : ebts_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			state <= ebts_pkg::ST_IDLE;
		else
			state <= next_state;
	end

	// ----------------------------------------------------------------
	// Operand tracking
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			remain       <= 3'h0;
			wbuf         <= 32'h00000000;
			rbuf         <= 32'h00000000;
			retryPending <= 1'b0;
			intAck       <= 1'b0;
		end else if (reqStart) begin
			remain       <= reqBytes;
			wbuf         <= wbufStart;
			rbuf         <= 32'h00000000;
			retryPending <= 1'b0;
			intAck       <= reqIntAck;
		end else if (cycleEnd) begin
			// Fault with halt repeats the cycle
			retryPending <= faultSeen & haltReq;
			if (faultSeen) begin
				if (!haltReq)
					remain <= 3'h0;
			end else if (avecHit) begin
				remain <= 3'h0;
			end else begin
				remain <= remainNew;
				wbuf   <= wbufNew;
				rbuf   <= rbufNew;
			end
		end else if (state == ebts_pkg::ST_HALT && next_state == ebts_pkg::ST_RUN) begin
			retryPending <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Bus monitor
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			monitorCount <= 8'h00;
		else if (running && !cycleEnd)
			monitorCount <= monitorCount + 8'h01;
		else
			monitorCount <= 8'h00;
	end

	// Silent while an external master owns the bus
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busFaultOut <= 1'b1;
			busFaultOe  <= 1'b0;
		end else begin
			busFaultOut <= 1'b0;
			busFaultOe  <= running & monitorExpired & ~faultPin & ~extMasterOwns;
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	wire nextRun  = (next_state == ebts_pkg::ST_RUN);
	wire advance  = cycleEnd & ~faultSeen & ~avecHit & ~lastPiece;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			addrOut        <= ebts_pkg::ADDR_RESET;
			space_code     <= ebts_pkg::SPACE_RESET;
			remaining_size <= ebts_pkg::SIZE_LONG;
			readNotWrite   <= 1'b1;
		end else if (reqStart) begin
			addrOut        <= reqAddr;
			space_code     <= reqSpace;
			remaining_size <= sizeCode(reqBytes);
			readNotWrite   <= ~reqWrite;
		end else if (advance) begin
			addrOut        <= addrNew;
			remaining_size <= sizeCode(remainNew);
		end
	end

	// Strobes and data released while halted
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cycleActive <= 1'b0;
			dataOe      <= 1'b0;
			dataOut     <= 16'h0000;
			addrOe      <= 1'b0;
		end else begin
			cycleActive <= nextRun;
			dataOe      <= nextRun & ~readNotWrite & ~reqStart | nextRun & reqStart & reqWrite;
			dataOut     <= reqStart ? startLanes : (advance ? nextLanes : writeLanes);
			addrOe      <= ~extMasterOwns;
		end
	end

	// ----------------------------------------------------------------
	// Core response
	// ----------------------------------------------------------------
	wire refused   = reqTake & (misaligned | badSize);
	wire finishOk  = cycleEnd & ~faultSeen & lastPiece;
	wire finishBad = cycleEnd & faultSeen & ~haltReq;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			respValid      <= 1'b0;
			respFault      <= 1'b0;
			respAutoVector <= 1'b0;
			respRdata      <= 32'h00000000;
			busIdle        <= 1'b1;
			irqServiceHold <= 1'b0;
		end else begin
			respValid      <= refused | finishOk | finishBad;
			respFault      <= refused | finishBad;
			respAutoVector <= finishOk & avecHit;
			if (finishOk && !avecHit)
				respRdata <= rbufNew;
			busIdle        <= (next_state == ebts_pkg::ST_IDLE);
			irqServiceHold <= (next_state == ebts_pkg::ST_HALT);
		end
	end

endmodule : ebts_core

`default_nettype wire

// ===== pkg/ebts_pkg.sv
// Constants and types shared by the bus termination and sizing logic.
// Assumes one 100 MHz clock and active-low strobes on the external pins.
`default_nettype none

package ebts_pkg;

	// ----------------------------------------------------------------
	// Remaining-size codes driven on the bus
	// ----------------------------------------------------------------
	localparam logic [1:0] SIZE_LONG  = 2'h0;
	localparam logic [1:0] SIZE_BYTE  = 2'h1;
	localparam logic [1:0] SIZE_WORD  = 2'h2;
	localparam logic [1:0] SIZE_THREE = 2'h3;

	// ----------------------------------------------------------------
	// Byte counts and lane layout
	// ----------------------------------------------------------------
	localparam logic [2:0] BYTES_LONG  = 3'h4;
	localparam logic [2:0] BYTES_THREE = 3'h3;
	localparam logic [2:0] BYTES_WORD  = 3'h2;
	localparam logic [2:0] BYTES_BYTE  = 3'h1;
	localparam int         LANE_HI_MSB = 15;
	localparam int         LANE_HI_LSB = 8;
	localparam int         OFFSET_BIT  = 0;

	// ----------------------------------------------------------------
	// Bus monitor
	// ----------------------------------------------------------------
	localparam int BUS_MONITOR_NS     = 640;
	localparam int CLOCK_PERIOD_NS    = 10;
	localparam int BUS_MONITOR_CYCLES = BUS_MONITOR_NS / CLOCK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Reset values of the pin side
	// ----------------------------------------------------------------
	localparam logic [23:0] ADDR_RESET  = 24'h000000;
	localparam logic [2:0]  SPACE_RESET = 3'h0;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN,
		ST_GAP,
		ST_HALT
	} ebts_state_t;

endpackage : ebts_pkg

`default_nettype wire

// ===== bench/ebts_core_chk.sv
// Assertions on the ports of the termination and sizing block.
// Assumes one clock domain; bound to every instance of the core.
`default_nettype none

module ebts_core_chk #(
	parameter int MONITOR_CYCLES = ebts_pkg::BUS_MONITOR_CYCLES
) (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_n,
	// Core side
	input wire logic        reqValid,
	input wire logic [2:0]  reqBytes,
	input wire logic [23:0] reqAddr,
	input wire logic        reqIntAck,
	input wire logic        respValid,
	input wire logic        respFault,
	input wire logic        respAutoVector,
	input wire logic        busIdle,
	input wire logic        irqServiceHold,
	input wire logic        extMasterOwns,
	// Pin side
	input wire logic [23:0] addrOut,
	input wire logic        addrOe,
	input wire logic [2:0]  space_code,
	input wire logic [1:0]  remaining_size,
	input wire logic        readNotWrite,
	input wire logic        cycleActive,
	input wire logic [15:0] dataOut,
	input wire logic        dataOe,
	input wire logic        busFaultOut,
	input wire logic        busFaultOe
);
	logic       takeNow;
	logic       intAck;
	logic [7:0] runCnt;

	assign takeNow = reqValid && busIdle && !extMasterOwns;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			intAck <= 1'b0;
			runCnt <= 8'h00;
		end else begin
			intAck <= takeNow ? reqIntAck : intAck;
			runCnt <= cycleActive ? runCnt + 8'h01 : 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	property p_refuse;
		takeNow && reqAddr[0] && reqBytes != 3'h1 |-> ##[1:2] respValid && respFault;
	endproperty
	a_refuse: assert property (p_refuse) else $error("misaligned not refused");
	property p_long_start;
		takeNow && !reqAddr[0] && reqBytes == 3'h4 |=> cycleActive
			&& remaining_size == ebts_pkg::SIZE_LONG && addrOut == $past(reqAddr);
	endproperty
	a_long_start: assert property (p_long_start) else $error("bad first piece");
	property p_halt_float;
		irqServiceHold |-> !cycleActive && !dataOe;
	endproperty
	a_halt_float: assert property (p_halt_float) else $error("bus driven in halt");
	property p_halt_hold;
		irqServiceHold && $past(irqServiceHold) |-> $stable(addrOut) && $stable(space_code)
			&& $stable(remaining_size) && $stable(readNotWrite);
	endproperty
	a_halt_hold: assert property (p_halt_hold) else $error("pins moved in halt");
	property p_byte_dup;
		cycleActive && !readNotWrite && remaining_size == ebts_pkg::SIZE_BYTE
			|-> dataOut[15:8] == dataOut[7:0];
	endproperty
	a_byte_dup: assert property (p_byte_dup) else $error("byte not on both lanes");
	property p_auto_vector_request;
		respAutoVector |-> respValid && intAck;
	endproperty
	a_auto_vector_request: assert property (p_auto_vector_request) else $error("autovector outside ack");
	property p_monitor;
		runCnt <= MONITOR_CYCLES + 6;
	endproperty
	a_monitor: assert property (p_monitor) else $error("monitor did not end");
	property p_fault_oe;
		busFaultOe |-> !busFaultOut && !$past(extMasterOwns);
	endproperty
	a_fault_oe: assert property (p_fault_oe) else $error("bad fault drive");
	property p_addr_oe;
		$past(rst_n) |-> addrOe == !$past(extMasterOwns);
	endproperty
	a_addr_oe: assert property (p_addr_oe) else $error("address drive wrong");

	c_auto_vector_request: cover property (respValid && respAutoVector);
	c_halt: cover property (irqServiceHold);
	c_fault: cover property (busFaultOe);

endmodule : ebts_core_chk

bind ebts_core ebts_core_chk #(.MONITOR_CYCLES(MONITOR_CYCLES)) u_chk (
	.ref_clk, .rst_n, .reqValid, .reqBytes, .reqAddr, .reqIntAck, .respValid,
	.respFault, .respAutoVector, .busIdle, .irqServiceHold, .extMasterOwns,
	.addrOut, .addrOe, .space_code, .remaining_size, .readNotWrite,
	.cycleActive, .dataOut, .dataOe, .busFaultOut, .busFaultOe
);

`default_nettype wire

// ===== bench/ebts_mem_model.sv
// Behavioural memory or peripheral on the far side of the bus pins.
// Assumes the bench picks port width, wait count and fault modes.
`default_nettype none

module ebts_mem_model (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Bus pins of the device
	input  wire logic [23:0] addrOut,
	input  wire logic [1:0]  remaining_size,
	input  wire logic        readNotWrite,
	input  wire logic        cycleActive,
	input  wire logic [15:0] dataOut,
	output logic      [15:0] dataIn,
	output logic             port_size_ack_hi_n,
	output logic             port_size_ack_lo_n,
	output logic             auto_vector_request_n,
	output logic             busFaultIn_n,
	// Behaviour controls
	input  wire logic        wide,
	input  wire logic        mute,
	input  wire logic        auto_vector_request,
	input  wire logic        flt,
	input  wire logic [1:0]  waitCyc
);
	logic [7:0]  mem [256];
	logic [2:0]  cnt;
	logic        done;
	logic        term;
	logic [7:0]  a;
	logic [15:0] last;

	assign a = addrOut[7:0];
	assign term = done && cycleActive && !mute;
	assign port_size_ack_hi_n = !(term && !auto_vector_request && wide);
	assign port_size_ack_lo_n = !(term && !auto_vector_request && !wide);
	assign auto_vector_request_n = !(term && auto_vector_request);
	assign busFaultIn_n = !(term && flt);
	assign dataIn = !cycleActive ? ~last : !wide ? {mem[a], ~last[7:0]}
		: {mem[{a[7:1], 1'b0}], mem[{a[7:1], 1'b1}]};

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 3'h0;
			done <= 1'b0;
			last <= 16'h0000;
			for (int i = 0; i < 256; i++)
				mem[i] <= 8'(i) ^ 8'h5A;
		end else begin
			last <= dataIn;
			cnt <= cycleActive ? cnt + 3'h1 : 3'h0;
			done <= cycleActive && (done || cnt == {1'b0, waitCyc});
			if (cycleActive && !done && cnt == {1'b0, waitCyc} && !readNotWrite && !mute) begin
				if (!wide || (remaining_size == ebts_pkg::SIZE_BYTE && !a[0]))
					mem[a] <= dataOut[15:8];
				else if (a[0])
					mem[a] <= dataOut[7:0];
				else begin
					mem[a] <= dataOut[15:8];
					mem[a | 8'h01] <= dataOut[7:0];
				end
			end
		end
	end

endmodule : ebts_mem_model

`default_nettype wire

// ===== bench/ebts_core_tb_top.sv
// Self-checking bench for the termination and sizing block.
// Assumes the bound checker and the memory model beside the design.
`default_nettype none

`define EBTS_CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module ebts_core_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	// Design inputs, with some outputs and bookkeeping
	logic        ref_clk, rst_n, reqValid, reqWrite, reqIntAck, csAckValid;
	logic        csAckWide, csAutoVector, extMasterOwns, haltRequest_n;
	logic [2:0]  reqBytes, reqSpace, space_code, n;
	logic [23:0] reqAddr, addrOut;
	logic [31:0] reqWdata, respRdata, d;
	// Outputs, pins and bookkeeping
	logic        respValid, respFault, respAutoVector, busIdle, irqServiceHold;
	logic        addrOe, readNotWrite, cycleActive, dataOe, busFaultOut, busFaultOe;
	logic        port_size_ack_hi_n, port_size_ack_lo_n, auto_vector_request_n;
	logic        faultN, busFaultIn_n, wide, mute, auto_vector_request, flt;
	logic [1:0]  remaining_size, waitCyc;
	logic [15:0] dataIn, dataOut;
	logic [7:0]  a;
	logic [7:0]  sh [256];
	integer      seed;
	int          n_mismatch, total_checks, i, j;

	// Open-drain fault line
	assign busFaultIn_n = faultN && !busFaultOe;

	ebts_core #(.MONITOR_CYCLES(8)) dut (
		.ref_clk, .rst_n, .reqValid, .reqWrite, .reqBytes, .reqAddr, .reqSpace,
		.reqIntAck, .reqWdata, .respValid, .respFault, .respAutoVector, .respRdata,
		.busIdle, .irqServiceHold, .csAckValid, .csAckWide, .csAutoVector,
		.extMasterOwns, .addrOut, .addrOe, .space_code, .remaining_size,
		.readNotWrite, .cycleActive, .dataIn, .dataOut, .dataOe,
		.port_size_ack_hi_n, .port_size_ack_lo_n, .auto_vector_request_n,
		.haltRequest_n, .busFaultIn_n, .busFaultOut, .busFaultOe
	);

	ebts_mem_model mem (
		.ref_clk, .rst_n, .addrOut, .remaining_size, .readNotWrite, .cycleActive,
		.dataOut, .dataIn, .port_size_ack_hi_n, .port_size_ack_lo_n,
		.auto_vector_request_n, .busFaultIn_n(faultN), .wide, .mute, .auto_vector_request, .flt,
		.waitCyc
	);

	// ----------------------------------------------------------------
	// Tasks and expectations
	// ----------------------------------------------------------------
	function automatic logic [31:0] exp_rd(input logic [7:0] ad, input logic [2:0] nb);
		logic [31:0] r;
		r = 32'h0;
		for (int k = 0; k < nb; k++)
			r = {r[23:0], sh[8'(ad + k)]};
		return r;
	endfunction : exp_rd

	task automatic close_out;
		$display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out

	task automatic xfer(input logic w, input logic [2:0] nb, input logic [7:0] ad,
			input logic [31:0] wd, input logic ia, input logic ef, input logic ev);
		logic [31:0] m;
		m = 32'hFFFFFFFF >> (32 - 8 * nb);
		for (int k = 0; k < 50 && (k == 0 || busIdle !== 1'b1); k++) begin
			@(posedge ref_clk);
			#1;
		end
		reqWrite = w;
		reqBytes = nb;
		reqAddr = {16'h0000, ad};
		reqWdata = wd;
		reqIntAck = ia;
		reqValid = 1'b1;
		@(posedge ref_clk);
		#1;
		reqValid = 1'b0;
		for (int k = 0; k < 400 && respValid !== 1'b1; k++) begin
			@(posedge ref_clk);
			#1;
		end
		`EBTS_CHK("resp", 1'b1, respValid)
		`EBTS_CHK("fault", ef, respFault)
		`EBTS_CHK("auto_vector_request", ev, respAutoVector)
		if (!ef) begin
			`EBTS_CHK("space", reqSpace, space_code)
			`EBTS_CHK("dir", ~w, readNotWrite)
		end
		if (!w && !ef && !ev)
			`EBTS_CHK("rdata", exp_rd(ad, nb) & m, respRdata & m)
		if (w && !ef)
			for (int k = 0; k < nb; k++)
				sh[8'(ad + k)] = 8'(wd >> (8 * (nb - 1 - k)));
	endtask : xfer

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		close_out;
	end

	initial begin
		{rst_n, reqValid, reqWrite, reqIntAck, csAckValid, csAckWide} = 6'h00;
		{csAutoVector, extMasterOwns, mute, auto_vector_request, flt, waitCyc} = 7'h00;
		{reqBytes, reqSpace, reqAddr, reqWdata} = 62'h0;
		{haltRequest_n, wide, seed} = {2'h3, 32'hAA3B1797};
		for (i = 0; i < 256; i++)
			sh[i] = 8'(i) ^ 8'h5A;
		repeat (20) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
		repeat (40) begin
			d = $random(seed);
			{wide, waitCyc, reqSpace} = d[13:8];
			n = (d[17:16] == 2'h0) ? 3'h1 : (d[17:16] == 2'h1) ? 3'h2 : 3'h4;
			a = d[31:24] & ((n == 3'h1) ? 8'hFF : 8'hFE);
			d = $random(seed);
			xfer(1'b1, n, a, d, 1'b0, 1'b0, 1'b0);
			xfer(1'b0, n, a, 32'h0, 1'b0, 1'b0, 1'b0);
		end
		{waitCyc, wide} = 3'h1;
		xfer(1'b0, 3'h2, 8'h11, 32'h0, 1'b0, 1'b1, 1'b0);
		xfer(1'b1, 3'h4, 8'h23, 32'h0, 1'b0, 1'b1, 1'b0);
		mute = 1'b1;
		xfer(1'b0, 3'h2, 8'h30, 32'h0, 1'b0, 1'b1, 1'b0);
		{csAckValid, csAckWide} = 2'h3;
		xfer(1'b0, 3'h2, 8'h30, 32'h0, 1'b0, 1'b0, 1'b0);
		{csAckValid, csAutoVector} = 2'h1;
		xfer(1'b0, 3'h1, 8'h31, 32'h0, 1'b1, 1'b0, 1'b1);
		{csAutoVector, mute, auto_vector_request} = 3'h1;
		xfer(1'b0, 3'h1, 8'h31, 32'h0, 1'b1, 1'b0, 1'b1);
		xfer(1'b0, 3'h1, 8'h31, 32'h0, 1'b0, 1'b1, 1'b0);
		{auto_vector_request, flt} = 2'h1;
		xfer(1'b0, 3'h2, 8'h40, 32'h0, 1'b0, 1'b1, 1'b0);
		{wide, haltRequest_n} = 2'h0;
		fork
			xfer(1'b0, 3'h4, 8'h44, 32'h0, 1'b0, 1'b0, 1'b0);
			begin
				for (j = 0; j < 200 && irqServiceHold !== 1'b1; j++) begin
					@(posedge ref_clk);
					#1;
				end
				`EBTS_CHK("halted", 1'b1, irqServiceHold)
				`EBTS_CHK("float", 1'b0, dataOe)
				{flt, haltRequest_n} = 2'h1;
			end
		join
		extMasterOwns = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		`EBTS_CHK("addr off", 1'b0, addrOe)
		extMasterOwns = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		`EBTS_CHK("addr on", 1'b1, addrOe)
		close_out;
	end

endmodule : ebts_core_tb_top

`default_nettype wire
